/* npsc_top.sv */
// Purpose: Network path state machines, one per possible path identifier
// Assumes: Control bits arrive synchronous to the management clock
// Notes:   Resource completion comes from the datapath as a per-path level
`include "npsc_cfg.svh"
module npsc_top (
	input  wire logic                    i_sys_clk,       // Management clock
	input  wire logic                    i_resetn,        // Async reset, low
	input  wire npsc_pkg::npsc_mod_st_t  i_module_state,  // Module state machine
	input  wire logic                    i_cfg_update,    // Active config rewritten
	input  wire npsc_pkg::npsc_path_cfg_t i_path_cfg [`NPSC_LANES], // Per path config
	input  wire npsc_pkg::npsc_lane_ctl_t i_lane_ctl,     // Lane control bits
	input  wire logic [`NPSC_LANES-1:0]  i_res_done,      // Path resources done
	input  wire logic [`NPSC_LANES-1:0]  i_flag_clear,    // Flag clear per lane
	output logic [`NPSC_LANES-1:0]       o_path_exists,   // Machine present
	output logic [`NPSC_ST_W-1:0]        o_lane_state [`NPSC_LANES], // State per lane
	output logic [`NPSC_LANES-1:0]       o_path_state_change_flag, // Sticky flag
	output logic [`NPSC_LANES-1:0]       o_path_powered   // Path resources powered
);
	npsc_pkg::npsc_path_st_t st_q [`NPSC_LANES];
	npsc_pkg::npsc_path_st_t st_d [`NPSC_LANES];
	logic [`NPSC_LANES-1:0]  deact;
	logic [`NPSC_LANES-1:0]  in_use;
	logic [`NPSC_LANES-1:0]  defined;
	logic [`NPSC_LANES-1:0]  entered_steady;
	logic [`NPSC_LANES-1:0]  lane_owner_chg;
	logic [`NPSC_LANE_W-1:0] owner [`NPSC_LANES];
	logic                    resetting;
	logic                    mod_ready;
	logic                    cfg_window;

	assign resetting  = i_module_state == npsc_pkg::NPSC_MOD_RESETTING;
	assign mod_ready  = i_module_state == npsc_pkg::NPSC_MOD_READY;
	assign cfg_window = (i_module_state == npsc_pkg::NPSC_MOD_LOW_POWER) | mod_ready;

	// One term block per possible path identifier
	for (genvar p = 0; p < `NPSC_LANES; p++) begin : g_path
		npsc_terms u_terms (
			.i_first_host (`NPSC_LANE_W'(p)),
			.i_cfg        (i_path_cfg[p]),
			.i_ctl        (i_lane_ctl),
			.o_in_use     (in_use[p]),
			.o_deactivate (deact[p])
		);
		assign defined[p] = i_path_cfg[p].defined & in_use[p];
	end

	always_comb begin
		for (int p = 0; p < `NPSC_LANES; p++) begin
			st_d[p] = st_q[p];
			unique case (st_q[p])
				npsc_pkg::NPSC_ABSENT: begin
					if ((i_module_state == npsc_pkg::NPSC_MOD_MGMT_INIT) && defined[p]) begin
						st_d[p] = npsc_pkg::NPSC_INACT;
					end else if (cfg_window && i_cfg_update && defined[p]) begin
						st_d[p] = npsc_pkg::NPSC_INACT;
					end
				end
				npsc_pkg::NPSC_INACT: begin
					if (mod_ready && !deact[p]) begin
						st_d[p] = npsc_pkg::NPSC_INIT;
					end
				end
				npsc_pkg::NPSC_INIT: begin
					if (deact[p]) begin
						st_d[p] = npsc_pkg::NPSC_DEINIT;
					end else if (i_res_done[p]) begin
						st_d[p] = npsc_pkg::NPSC_READY;
					end
				end
				npsc_pkg::NPSC_READY: begin
					if (deact[p] || !mod_ready) begin
						st_d[p] = npsc_pkg::NPSC_DEINIT;
					end
				end
				npsc_pkg::NPSC_DEINIT: begin
					if (i_res_done[p]) begin
						st_d[p] = npsc_pkg::NPSC_INACT;
					end
				end
			endcase
			// Teardown of paths no longer defined; overrides any transition in the case above
			if (st_q[p] != npsc_pkg::NPSC_ABSENT && cfg_window && i_cfg_update && !defined[p]) begin
				st_d[p] = npsc_pkg::NPSC_ABSENT;
			end
		end
	end

	// Each machine updates only from its own terms
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int p = 0; p < `NPSC_LANES; p++) begin
				st_q[p] <= npsc_pkg::NPSC_ABSENT;
			end
		end else begin
			for (int p = 0; p < `NPSC_LANES; p++) begin
				if (resetting) begin
					st_q[p] <= npsc_pkg::NPSC_ABSENT;
				end else begin
					st_q[p] <= st_d[p];
				end
			end
		end
	end

	// Power down while resetting; machines are then gone
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_path_powered <= '0;
		end else begin
			for (int p = 0; p < `NPSC_LANES; p++) begin
				o_path_powered[p] <= !resetting && (st_q[p] == npsc_pkg::NPSC_READY
					|| st_q[p] == npsc_pkg::NPSC_INIT);
			end
		end
	end

	// Lane owner is the highest present path id whose host lanes cover the lane, else path 0
	always_comb begin
		for (int l = 0; l < `NPSC_LANES; l++) begin
			owner[l] = '0;
			for (int p = 0; p <= l; p++) begin
				if (st_q[p] != npsc_pkg::NPSC_ABSENT
					&& l < p + int'(i_path_cfg[p].host_count)) begin
					owner[l] = `NPSC_LANE_W'(p);
				end
			end
		end
	end

	for (genvar p = 0; p < `NPSC_LANES; p++) begin : g_steady
		assign entered_steady[p] = (st_d[p] != st_q[p]) && !resetting
			&& (st_d[p] == npsc_pkg::NPSC_READY || st_d[p] == npsc_pkg::NPSC_INACT);
	end

	always_comb begin
		for (int l = 0; l < `NPSC_LANES; l++) begin
			lane_owner_chg[l] = entered_steady[owner[l]]
				&& st_q[owner[l]] != npsc_pkg::NPSC_ABSENT
				&& l < int'(owner[l]) + int'(i_path_cfg[owner[l]].host_count);
		end
	end

	// Set wins over a same-cycle clear
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_path_state_change_flag <= '0;
		end else begin
			o_path_state_change_flag <= (o_path_state_change_flag & ~i_flag_clear)
				| lane_owner_chg;
		end
	end

	// Same code on every lane of the path
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int l = 0; l < `NPSC_LANES; l++) begin
				o_lane_state[l] <= `NPSC_ST_W'(npsc_pkg::NPSC_ABSENT);
			end
			o_path_exists <= '0;
		end else begin
			for (int l = 0; l < `NPSC_LANES; l++) begin
				o_lane_state[l] <= st_q[owner[l]];
				o_path_exists[l] <= st_q[l] != npsc_pkg::NPSC_ABSENT;
			end
		end
	end

	AST_RESET_CLEARS: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		resetting |=> st_q[0] == npsc_pkg::NPSC_ABSENT && st_q[7] == npsc_pkg::NPSC_ABSENT)
		else $error("Path machine survived resetting");
	AST_STAY_INACT: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st_q[0] == npsc_pkg::NPSC_INACT && !mod_ready && !resetting && !i_cfg_update)
		|=> st_q[0] == npsc_pkg::NPSC_INACT)
		else $error("Path left inactive before module ready");
	AST_DEACT_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st_q[0] == npsc_pkg::NPSC_READY && deact[0] && !resetting && !i_cfg_update)
		|=> st_q[0] == npsc_pkg::NPSC_DEINIT)
		else $error("Deactivate ignored in ready");
	AST_WAIT_DONE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st_q[0] == npsc_pkg::NPSC_INIT && !i_res_done[0] && !deact[0] && !resetting
		&& !i_cfg_update) |=> st_q[0] == npsc_pkg::NPSC_INIT)
		else $error("State reported before resources done");
	AST_FLAG_STICKY: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(o_path_state_change_flag[0] && !i_flag_clear[0]) |=> o_path_state_change_flag[0])
		else $error("Flag dropped without clear");
	AST_CREATE_INIT: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st_q[0] == npsc_pkg::NPSC_ABSENT && i_module_state == npsc_pkg::NPSC_MOD_MGMT_INIT
		&& defined[0]) |=> st_q[0] == npsc_pkg::NPSC_INACT)
		else $error("Default path not created");
	AST_TEARDOWN: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(cfg_window && i_cfg_update && !defined[4]) |=> st_q[4] == npsc_pkg::NPSC_ABSENT)
		else $error("Undefined path not torn down");
	// Path 4 is the one the bench tears down, squelches and recreates
	AST_DEACT_BLOCKS: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st_q[4] == npsc_pkg::NPSC_INACT && deact[4] && !resetting && !i_cfg_update)
		|=> st_q[4] == npsc_pkg::NPSC_INACT)
		else $error("Path left inactive while deactivated");
	AST_FLAG_SET_WINS: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		lane_owner_chg[4] |=> o_path_state_change_flag[4])
		else $error("State change flag not set");
	AST_POWER_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		resetting |=> o_path_powered == '0)
		else $error("Path still powered while resetting");
	AST_LANE_MIRROR: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		owner[1] == 3'h0 |=> o_lane_state[1] == $past(st_q[0]))
		else $error("Lane state differs from path state");
endmodule : npsc_top

/* npsc_cfg.svh */
// Purpose: Constants for the network path state control block
// Assumes: Eight host lanes, eight media lanes, one path per lowest host lane
// Notes:   Timing counts are in management clock cycles
`ifndef NPSC_CFG_SVH
`define NPSC_CFG_SVH
`define NPSC_LANES        8
`define NPSC_LANE_W       3
`define NPSC_CNT_W        4
`define NPSC_CLK_MHZ      10
`define NPSC_INIT_TIME_US 2
`define NPSC_INIT_CYC     ((`NPSC_INIT_TIME_US * `NPSC_CLK_MHZ) > 0 ? (`NPSC_INIT_TIME_US * `NPSC_CLK_MHZ) : 1)
`define NPSC_ST_W         5
`endif

/* npsc_pkg.sv */
// Purpose: Types for the network path state control block
// Assumes: Constants come from npsc_cfg.svh
// Notes:   Path state codes are one-hot
`include "npsc_cfg.svh"
package npsc_pkg;
	typedef enum logic [`NPSC_ST_W-1:0] {
		NPSC_ABSENT  = 5'b0_0001,
		NPSC_INACT   = 5'b0_0010,
		NPSC_INIT    = 5'b0_0100,
		NPSC_READY   = 5'b0_1000,
		NPSC_DEINIT  = 5'b1_0000
	} npsc_path_st_t;
	typedef enum logic [3:0] {
		NPSC_MOD_RESETTING = 4'b0001,
		NPSC_MOD_MGMT_INIT = 4'b0010,
		NPSC_MOD_LOW_POWER = 4'b0100,
		NPSC_MOD_READY     = 4'b1000
	} npsc_mod_st_t;
	typedef struct packed {
		logic [`NPSC_LANE_W-1:0] first_media;
		logic [`NPSC_CNT_W-1:0]  media_count;
		logic [`NPSC_CNT_W-1:0]  host_count;
		logic                    defined;
	} npsc_path_cfg_t;
	typedef struct packed {
		logic [`NPSC_LANES-1:0] lane_path_membership;
		logic [`NPSC_LANES-1:0] path_deinit_control;
		logic [`NPSC_LANES-1:0] media_lane_out_disable;
		logic [`NPSC_LANES-1:0] media_lane_squelch_force;
	} npsc_lane_ctl_t;
endpackage : npsc_pkg

/* npsc_terms.sv */
// Purpose: Combinational terms feeding one network path state machine
// Assumes: Lane ranges never wrap past the last lane
// Notes:   Pure logic, evaluated every cycle
`include "npsc_cfg.svh"
module npsc_terms (
	input  wire logic [`NPSC_LANE_W-1:0] i_first_host,   // First host lane of path
	input  wire npsc_pkg::npsc_path_cfg_t i_cfg,        // Path configuration
	input  wire npsc_pkg::npsc_lane_ctl_t i_ctl,        // Lane control bits
	output logic                         o_in_use,       // Path in use term
	output logic                         o_deactivate    // Deactivate signal
);
	// Lane window mask from first lane and count
	function automatic logic [`NPSC_LANES-1:0] npsc_mask(
		input logic [`NPSC_LANE_W-1:0] first,
		input logic [`NPSC_CNT_W-1:0]  count
	);
		logic [`NPSC_LANES-1:0] m;
		m = '0;
		for (int k = 0; k < `NPSC_LANES; k++) begin
			if (k >= int'(first) && k < int'(first) + int'(count)) begin
				m[k] = 1'b1;
			end
		end
		return m;
	endfunction : npsc_mask

	logic [`NPSC_LANES-1:0] host_mask;
	logic [`NPSC_LANES-1:0] media_mask;
	logic                   deinit_sig;
	logic                   tx_off;
	logic                   tx_squelch;

	assign host_mask  = npsc_mask(i_first_host, i_cfg.host_count);
	assign media_mask = npsc_mask(i_cfg.first_media, i_cfg.media_count);
	assign o_in_use   = |(i_ctl.lane_path_membership & host_mask);
	assign deinit_sig = |(i_ctl.path_deinit_control & host_mask);
	assign tx_off     = |(i_ctl.media_lane_out_disable & media_mask);
	assign tx_squelch = |(i_ctl.media_lane_squelch_force & media_mask);
	assign o_deactivate = deinit_sig | tx_off | tx_squelch;
endmodule : npsc_terms

/* npsc_host.sv */
// Purpose: Host model driving the lane control bits over management writes
// Assumes: Requests change just after a clock edge
// Notes:   Deinit bits land one edge after the other settings
module npsc_host (
	input  wire logic                    i_sys_clk, // Management clock
	input  wire logic [7:0]              i_member,  // Lane membership
	input  wire logic [7:0]              i_off,     // Output disable
	input  wire logic [7:0]              i_sq,      // Squelch force
	input  wire logic [7:0]              i_deinit,  // Deinit request
	output npsc_pkg::npsc_lane_ctl_t     o_ctl      // Lane control bits
);
	logic [7:0] deinit_q;
	// Settings first, then the deinit write
	always_ff @(posedge i_sys_clk) begin
		o_ctl.lane_path_membership     <= i_member;
		o_ctl.media_lane_out_disable   <= i_off;
		o_ctl.media_lane_squelch_force <= i_sq;
		deinit_q                       <= i_deinit;
		o_ctl.path_deinit_control      <= deinit_q;
	end
endmodule : npsc_host

/* network_path_state_control_test.sv */
// Purpose: Self-checking bench for the network path state machines
// Assumes: Paths 0 and 4, two host and two media lanes each
// Notes:   Outputs are sampled on the falling edge
module network_path_state_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic                     sys_clk, resetn, cfg_update;
	npsc_pkg::npsc_mod_st_t   mod_st;
	npsc_pkg::npsc_path_cfg_t path_cfg [8];
	npsc_pkg::npsc_lane_ctl_t lane_ctl;
	logic [7:0]               member, off, sq, deinit, res_done, exists, flag;
	logic [7:0]               flag_clr, powered;
	logic [4:0]               lane_st [8];
	int                       n_fail, total_checks, cyc;
	npsc_host npsc_host_i (.i_sys_clk(sys_clk), .i_member(member), .i_off(off), .i_sq(sq),
		.i_deinit(deinit), .o_ctl(lane_ctl));
	npsc_top npsc_top_i (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_module_state(mod_st),
		.i_cfg_update(cfg_update), .i_path_cfg(path_cfg), .i_lane_ctl(lane_ctl),
		.i_res_done(res_done), .i_flag_clear(flag_clr), .o_path_exists(exists),
		.o_lane_state(lane_st), .o_path_state_change_flag(flag), .o_path_powered(powered));
	always #50 sys_clk = ~sys_clk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic wait_st(input int l, input logic [4:0] s);
		for (int i = 0; i < 40 && lane_st[l] !== s; i++) @(negedge sys_clk);
		chk({3'h0, lane_st[l]}, {3'h0, s});
	endtask : wait_st
	task automatic go(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : go
	task automatic t_create();
		go(4);
		@(negedge sys_clk);
		chk(exists, 8'h11);
		chk({3'h0, lane_st[1]}, {3'h0, npsc_pkg::NPSC_INACT});
		chk({3'h0, lane_st[5]}, {3'h0, npsc_pkg::NPSC_INACT});
	endtask : t_create
	task automatic t_ready();
		go(1);
		mod_st <= npsc_pkg::NPSC_MOD_LOW_POWER;
		deinit <= 8'h00;
		go(8);
		@(negedge sys_clk);
		chk({3'h0, lane_st[0]}, {3'h0, npsc_pkg::NPSC_INACT});
		go(1);
		mod_st <= npsc_pkg::NPSC_MOD_READY;
		wait_st(0, npsc_pkg::NPSC_INIT);
		go(6);
		@(negedge sys_clk);
		chk({3'h0, lane_st[1]}, {3'h0, npsc_pkg::NPSC_INIT});
		go(1);
		res_done <= 8'h01;
		wait_st(1, npsc_pkg::NPSC_READY);
		chk(flag & 8'h33, 8'h03);
		chk({3'h0, lane_st[4]}, {3'h0, npsc_pkg::NPSC_INIT});
		go(1);
		res_done <= 8'hff;
		flag_clr <= 8'h30;
		go(1);
		flag_clr <= 8'h00;
		wait_st(4, npsc_pkg::NPSC_READY);
		chk(flag & 8'h30, 8'h30);
		chk(powered, 8'h11);
	endtask : t_ready
	task automatic t_deact();
		go(1);
		off <= 8'h02;
		wait_st(0, npsc_pkg::NPSC_INACT);
		chk({3'h0, lane_st[4]}, {3'h0, npsc_pkg::NPSC_READY});
		go(1);
		off <= 8'h00;
		sq  <= 8'h20;
		wait_st(4, npsc_pkg::NPSC_INACT);
		wait_st(0, npsc_pkg::NPSC_READY);
		go(1);
		deinit <= 8'h03;
		wait_st(1, npsc_pkg::NPSC_INACT);
		go(1);
		flag_clr <= 8'hff;
		go(1);
		flag_clr <= 8'h00;
		@(negedge sys_clk);
		chk(flag, 8'h00);
	endtask : t_deact
	task automatic t_reconf();
		go(1);
		path_cfg[4].defined <= 1'b0;
		cfg_update          <= 1'b1;
		go(1);
		cfg_update <= 1'b0;
		go(4);
		@(negedge sys_clk);
		chk(exists, 8'h01);
		go(1);
		path_cfg[4].defined <= 1'b1;
		cfg_update          <= 1'b1;
		go(1);
		cfg_update <= 1'b0;
		go(3);
		@(negedge sys_clk);
		chk(exists, 8'h11);
		chk({3'h0, lane_st[5]}, {3'h0, npsc_pkg::NPSC_INACT});
		go(1);
		mod_st <= npsc_pkg::NPSC_MOD_RESETTING;
		go(4);
		@(negedge sys_clk);
		chk(exists, 8'h00);
		chk(powered, 8'h00);
		chk({3'h0, lane_st[0]}, {3'h0, npsc_pkg::NPSC_ABSENT});
	endtask : t_reconf
	initial begin
		sys_clk = 0; resetn = 0; cfg_update = 0; n_fail = 0; total_checks = 0; cyc = 0;
		mod_st = npsc_pkg::NPSC_MOD_MGMT_INIT;
		for (int p = 0; p < 8; p++) path_cfg[p] = '0;
		path_cfg[0] = '{3'h0, 4'h2, 4'h2, 1'b1};
		path_cfg[4] = '{3'h4, 4'h2, 4'h2, 1'b1};
		member = 8'h33; off = 8'h00; sq = 8'h00; deinit = 8'hff; res_done = 8'h00;
		flag_clr = 8'h00;
		go(12);
		resetn <= 1'b1;
		t_create();
		t_ready();
		t_deact();
		t_reconf();
		stop_test();
	end
endmodule : network_path_state_control_test
